// File: rtl/pmca_map.svh
// Offsets, field positions, reset values and counts for the per-port counter access block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef PMCA_MAP_SVH
`define PMCA_MAP_SVH
// ====================================================================
// Register offsets
`define PMCA_OFS_CTRL 12'h500
`define PMCA_OFS_DATA 12'h504
`define PMCA_OFS_GLOB 12'h508
// ====================================================================
// Field positions
`define PMCA_BIT_OVF 31
`define PMCA_BIT_START 25
`define PMCA_BIT_FFEN 24
`define PMCA_IDX_HI 23
`define PMCA_IDX_LO 16
`define PMCA_HI_MSB 3
`define PMCA_BIT_GFLUSH 0
`define PMCA_BIT_GFREEZE 1
// ====================================================================
// Sizes and reset values
`define PMCA_NUM_CNT 30
`define PMCA_CNT_W 36
`define PMCA_RST_WORD 32'h00000000
`define PMCA_RST_IDX 8'h00
`define PMCA_RST_HI 4'h0
`endif

// File: rtl/pmca_pkg.sv
// Types shared by the per-port counter access block.
// Assumes the map header sits beside it in rtl/.
`include "pmca_map.svh"
package pmca_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pmca_apb_req_s;
   typedef enum logic [1:0] {
      PMCA_IDLE = 2'b01,
      PMCA_FETCH = 2'b10
   } pmca_state_e;
   typedef logic [`PMCA_CNT_W-1:0] pmca_cnt_t;
endpackage

// File: rtl/pmca_top.sv
// Per-port statistics counters with indirect access over an APB slave.
// Assumes count events arrive as one-cycle pulses synchronous to core_clk_i.
`timescale 1ns/1ps
`include "pmca_map.svh"
module pmca_top (
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire pmca_pkg::pmca_apb_req_s apb_i,
   input wire logic [`PMCA_NUM_CNT-1:0] cnt_evt_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);
   // ====================================================================
   // State
   pmca_pkg::pmca_state_e state_r, state_nxt;
   pmca_pkg::pmca_cnt_t cnt_r [`PMCA_NUM_CNT];
   pmca_pkg::pmca_cnt_t cnt_nxt [`PMCA_NUM_CNT];
   logic [`PMCA_NUM_CNT-1:0] ovf_r, ovf_nxt;
   logic start_r, start_nxt, ffen_r, ffen_nxt, ovf_flag_r, ovf_flag_nxt;
   logic freeze_r, freeze_nxt, flush_r, flush_nxt;
   logic [7:0] idx_r, idx_nxt;
   logic [3:0] hi_r, hi_nxt;
   logic [31:0] data_r, data_nxt, prdata_nxt;
   logic pready_nxt, pslverr_nxt;
   logic wr_fire, rd_phase, sel_ovf, sel_evt, idx_ok;
   pmca_pkg::pmca_cnt_t sel_cnt;

   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = (a == `PMCA_OFS_CTRL) || (a == `PMCA_OFS_DATA) || (a == `PMCA_OFS_GLOB);
   endfunction

   assign wr_fire = apb_i.psel && apb_i.penable && pready_o && apb_i.pwrite;
   assign rd_phase = apb_i.psel && apb_i.penable && !pready_o;
   assign idx_ok = idx_r < 8'(`PMCA_NUM_CNT);
   // Out-of-range indexes read as zero rather than aliasing a real counter
   assign sel_cnt = idx_ok ? cnt_r[idx_r[4:0]] : '0;
   assign sel_ovf = idx_ok ? ovf_r[idx_r[4:0]] : 1'b0;
   assign sel_evt = idx_ok ? cnt_evt_i[idx_r[4:0]] : 1'b0;

   // ====================================================================
   // APB slave: one wait state, answer registered
   always_comb begin
      pready_nxt = rd_phase;
      pslverr_nxt = rd_phase && !addr_hit(apb_i.paddr);
      prdata_nxt = `PMCA_RST_WORD;
      if (rd_phase && !apb_i.pwrite) begin
         if (apb_i.paddr == `PMCA_OFS_CTRL) begin
            prdata_nxt[`PMCA_BIT_OVF] = ovf_flag_r;
            prdata_nxt[`PMCA_BIT_START] = start_r;
            prdata_nxt[`PMCA_BIT_FFEN] = ffen_r;
            prdata_nxt[`PMCA_IDX_HI:`PMCA_IDX_LO] = idx_r;
            prdata_nxt[`PMCA_HI_MSB:0] = hi_r;
         end else if (apb_i.paddr == `PMCA_OFS_DATA) begin
            prdata_nxt = data_r;
         end else if (apb_i.paddr == `PMCA_OFS_GLOB) begin
            prdata_nxt[`PMCA_BIT_GFREEZE] = freeze_r;
         end
      end
   end

   // ====================================================================
   // Control registers and read sequencer
   always_comb begin
      state_nxt = state_r;
      start_nxt = start_r;
      ffen_nxt = ffen_r;
      idx_nxt = idx_r;
      hi_nxt = hi_r;
      data_nxt = data_r;
      ovf_flag_nxt = ovf_flag_r;
      freeze_nxt = freeze_r;
      flush_nxt = 1'b0;
      case (state_r)
         pmca_pkg::PMCA_IDLE: begin
            if (wr_fire && apb_i.paddr == `PMCA_OFS_CTRL) begin
               ffen_nxt = apb_i.pwdata[`PMCA_BIT_FFEN];
               idx_nxt = apb_i.pwdata[`PMCA_IDX_HI:`PMCA_IDX_LO];
               if (apb_i.pwdata[`PMCA_BIT_START]) begin
                  start_nxt = 1'b1;
                  state_nxt = pmca_pkg::PMCA_FETCH;
               end
            end
         end
         pmca_pkg::PMCA_FETCH: begin
            data_nxt = sel_cnt[31:0];
            hi_nxt = sel_cnt[`PMCA_CNT_W-1:32];
            ovf_flag_nxt = sel_ovf;
            start_nxt = 1'b0;
            state_nxt = pmca_pkg::PMCA_IDLE;
         end
         default: begin
            state_nxt = pmca_pkg::PMCA_IDLE;
         end
      endcase
      // Index and enable writes during a fetch are dropped so the fetch stays coherent
      if (wr_fire && apb_i.paddr == `PMCA_OFS_GLOB) begin
         flush_nxt = apb_i.pwdata[`PMCA_BIT_GFLUSH];
         freeze_nxt = apb_i.pwdata[`PMCA_BIT_GFREEZE];
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= pmca_pkg::PMCA_IDLE;
         start_r <= 1'b0;
         ffen_r <= 1'b0;
         idx_r <= `PMCA_RST_IDX;
         hi_r <= `PMCA_RST_HI;
         data_r <= `PMCA_RST_WORD;
         ovf_flag_r <= 1'b0;
         freeze_r <= 1'b0;
         flush_r <= 1'b0;
         prdata_o <= `PMCA_RST_WORD;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         start_r <= start_nxt;
         ffen_r <= ffen_nxt;
         idx_r <= idx_nxt;
         hi_r <= hi_nxt;
         data_r <= data_nxt;
         ovf_flag_r <= ovf_flag_nxt;
         freeze_r <= freeze_nxt;
         flush_r <= flush_nxt;
         prdata_o <= prdata_nxt;
         pready_o <= pready_nxt;
         pslverr_o <= pslverr_nxt;
      end
   end

   // ====================================================================
   // Counter array; an event in a clearing cycle is kept as a count of one
   genvar gi;
   generate
      for (gi = 0; gi < `PMCA_NUM_CNT; gi++) begin : g_cnt
         logic rd_clr, fl_clr, frozen;
         assign rd_clr = (state_r == pmca_pkg::PMCA_FETCH) && (idx_r == 8'(gi));
         assign fl_clr = flush_r && ffen_r;
         assign frozen = freeze_r && ffen_r;
         always_comb begin
            cnt_nxt[gi] = cnt_r[gi];
            ovf_nxt[gi] = ovf_r[gi];
            if (rd_clr || fl_clr) begin
               cnt_nxt[gi] = {35'h000000000, cnt_evt_i[gi]};
               ovf_nxt[gi] = 1'b0;
            end else if (cnt_evt_i[gi] && !frozen) begin
               cnt_nxt[gi] = cnt_r[gi] + 36'h000000001;
               if (&cnt_r[gi]) begin
                  ovf_nxt[gi] = 1'b1;
               end
            end
         end
         always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
               cnt_r[gi] <= '0;
               ovf_r[gi] <= 1'b0;
            end else begin
               cnt_r[gi] <= cnt_nxt[gi];
               ovf_r[gi] <= ovf_nxt[gi];
            end
         end
      end
   endgenerate

   // ====================================================================
   // Assertions
   sequence s_fetch;
      state_r == pmca_pkg::PMCA_FETCH && !wr_fire;
   endsequence
   // A start must be picked up by the sequencer in the very cycle it shows
   property p_start_clear;
      @(posedge core_clk_i) disable iff (!reset_n_i) $rose(start_r) |-> s_fetch;
   endproperty
   a_start_clear: assert property (p_start_clear) else $error("read start not handled");
   property p_start_done;
      @(posedge core_clk_i) disable iff (!reset_n_i) $rose(start_r) |-> ##1 !start_r;
   endproperty
   a_start_done: assert property (p_start_done) else $error("start bit not cleared");
   property p_data;
      @(posedge core_clk_i) disable iff (!reset_n_i) s_fetch |=> data_r == 32'($past(sel_cnt));
   endproperty
   a_data: assert property (p_data) else $error("low count word wrong");
   property p_hi;
      @(posedge core_clk_i) disable iff (!reset_n_i) s_fetch |=> {hi_r, data_r} == $past(sel_cnt);
   endproperty
   a_hi: assert property (p_hi) else $error("high count bits wrong");
   property p_ovf;
      @(posedge core_clk_i) disable iff (!reset_n_i) s_fetch |=> ovf_flag_r == $past(sel_ovf);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
   property p_clear;
      @(posedge core_clk_i) disable iff (!reset_n_i) s_fetch ##0 !sel_evt |=> sel_cnt == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("counter not cleared by read");
   property p_flush;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         flush_r && ffen_r && !wr_fire |=> sel_cnt <= 36'h000000001;
   endproperty
   a_flush: assert property (p_flush) else $error("flush did not clear counter");
   property p_freeze;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         freeze_r && ffen_r && !flush_r && !wr_fire && state_r == pmca_pkg::PMCA_IDLE
         |=> $stable(sel_cnt);
   endproperty
   a_freeze: assert property (p_freeze) else $error("frozen counter moved");
   property p_count;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         sel_evt && !(freeze_r && ffen_r) && !flush_r && !wr_fire
         && state_r == pmca_pkg::PMCA_IDLE && !(&sel_cnt)
         |=> sel_cnt == $past(sel_cnt) + 36'h000000001;
   endproperty
   a_count: assert property (p_count) else $error("event not counted");
   property p_ready;
      @(posedge core_clk_i) disable iff (!reset_n_i) rd_phase |=> pready_o ##1 !pready_o;
   endproperty
   a_ready: assert property (p_ready) else $error("apb answer timing wrong");
   // Too slow to reach in simulation; kept for formal runs
   property p_wrap;
      @(posedge core_clk_i) disable iff (!reset_n_i)
         sel_evt && (&sel_cnt) && !(freeze_r && ffen_r) && !(flush_r && ffen_r) && !wr_fire
         && state_r == pmca_pkg::PMCA_IDLE |=> sel_ovf;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap did not set overflow");
   property p_err;
      @(posedge core_clk_i) disable iff (!reset_n_i) pslverr_o |-> pready_o;
   endproperty
   a_err: assert property (p_err) else $error("error shown without ready");
endmodule // pmca_top

// File: verif/tb_pmca_top.sv
// Self-checking bench for the per-port counter access block.
// Assumes the design package and map header are compiled first.
`timescale 1ns/1ps
`include "pmca_map.svh"
module tb_pmca_top;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} pmca_tb_exp_s;
   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   pmca_pkg::pmca_apb_req_s req = '0;
   logic [`PMCA_NUM_CNT-1:0] cnt_evt = '0;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   pmca_tb_exp_s q[$];
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   int cnt[30];
   always #2.5 core_clk_i = ~core_clk_i;
   pmca_top u_pmca_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .apb_i(req),
      .cnt_evt_i(cnt_evt), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
   // ====================================================================
   // Checking
   task report_and_stop;
      $display("Mismatches %0d, comparisons %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task compare(input logic [31:0] got, input logic ge, input pmca_tb_exp_s x);
      n_compared++;
      if (((got & x.m) !== (x.d & x.m)) || ge !== x.e) begin
         err_total++;
         $display("MISMATCH t=%0t got %h/%b exp %h/%b", $time, got, ge, x.d, x.e);
      end
   endtask
   // The oldest note belongs to the transfer now answering
   always @(negedge core_clk_i) if (pready_o === 1'b1) begin
      if (q.size() == 0) begin
         err_total++;
         $display("MISMATCH t=%0t answer with no request", $time);
      end else compare(prdata_o, pslverr_o, q.pop_front());
   end
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc > 20000) begin
         err_total++;
         report_and_stop;
      end
   end
   // ====================================================================
   // Stimulus
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      input logic [31:0] ex, input logic [31:0] m, input logic er);
      q.push_back('{ex, m, er});
      req <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge core_clk_i);
      req.penable <= 1'b1;
      // Waits as long as the slave needs; only the bench timeout ends a hang
      do @(negedge core_clk_i); while (pready_o !== 1'b1);
      @(posedge core_clk_i);
      req <= '0;
      // Idle edge keeps two request writes out of one time step
      @(posedge core_clk_i);
   endtask
   task automatic pulse(input logic [29:0] m, input int n, input bit add);
      for (int i = 0; i < 30; i++) if (m[i] && add) cnt[i] += n;
      repeat (n) begin
         cnt_evt <= m;
         @(posedge core_clk_i);
      end
      cnt_evt <= '0;
      @(posedge core_clk_i);
   endtask
   task automatic fetch(input int k, input logic ff, input int ex);
      logic [31:0] c;
      c = 32'h00000000;
      c[`PMCA_BIT_FFEN] = ff;
      c[`PMCA_IDX_HI:`PMCA_IDX_LO] = k[7:0];
      apb(1'b1, `PMCA_OFS_CTRL, c | 32'h02000000, '0, '0, 1'b0);
      apb(1'b0, `PMCA_OFS_CTRL, 32'h0, c, 32'hffffffff, 1'b0);
      apb(1'b0, `PMCA_OFS_DATA, 32'h0, ex, 32'hffffffff, 1'b0);
      if (k < 30) cnt[k] = 0;
   endtask
   initial begin
      logic [29:0] m;
      int k;
      void'($urandom(24));
      foreach (cnt[i]) cnt[i] = 0;
      repeat (2) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      @(posedge core_clk_i);
      apb(1'b0, `PMCA_OFS_CTRL, 32'h0, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b0, `PMCA_OFS_DATA, 32'h0, 32'h0, 32'hffffffff, 1'b0);
      apb(1'b0, 12'h50c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b1, `PMCA_OFS_DATA, 32'h5a5a5a5a, '0, '0, 1'b0);
      apb(1'b0, `PMCA_OFS_DATA, 32'h0, 32'h0, 32'hffffffff, 1'b0);
      for (int i = 0; i < 6; i++) begin
         m = 30'($urandom);
         pulse(m, 1 + $urandom % 20, 1'b1);
         k = $urandom % 30;
         fetch(k, 1'b0, cnt[k]);
         fetch(k, 1'b0, 0);
      end
      for (int i = 0; i < 30; i++) fetch(i, 1'b0, cnt[i]);
      // Out-of-range index only checks the design's choice of reading zero
      fetch(30, 1'b0, 0);
      // Flush with the port not enabled must leave counts alone
      pulse(30'h3fffffff, 5, 1'b1);
      apb(1'b1, `PMCA_OFS_CTRL, 32'h0, '0, '0, 1'b0);
      apb(1'b1, `PMCA_OFS_GLOB, 32'h1, '0, '0, 1'b0);
      fetch(4, 1'b0, cnt[4]);
      apb(1'b1, `PMCA_OFS_CTRL, 32'h01000000, '0, '0, 1'b0);
      apb(1'b1, `PMCA_OFS_GLOB, 32'h1, '0, '0, 1'b0);
      foreach (cnt[i]) cnt[i] = 0;
      fetch(7, 1'b1, 0);
      apb(1'b1, `PMCA_OFS_GLOB, 32'h2, '0, '0, 1'b0);
      apb(1'b0, `PMCA_OFS_GLOB, 32'h0, 32'h2, 32'h3, 1'b0);
      m = 30'($urandom);
      pulse(m | 30'h4, 3, 1'b0);
      fetch(2, 1'b1, 0);
      apb(1'b1, `PMCA_OFS_GLOB, 32'h0, '0, '0, 1'b0);
      pulse(30'h4, 2, 1'b1);
      fetch(2, 1'b1, cnt[2]);
      report_and_stop;
   end
endmodule // tb_pmca_top
